// ===== tb/spm_core_tb.sv
// self-checking bench for the serial port block
`timescale 1ns/10ps
module spm_core_tb;
  logic        clk_i = 0, rst_i = 1, ce_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic        wait_mode_i = 0, stop_mode_i = 0, sck_drv = 0, mosi_drv = 1, ss_drv = 1;
  logic [3:0]  avs_address_i = 0, avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = 0, avs_readdata_o, rdata;
  logic        avs_waitrequest_o, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o, miso_o;
  logic        miso_oe_n_o, ss_n_o, ss_oe_n_o, irq_o, mmiso, mdone, measure = 0, sck_p;
  logic [7:0]  mtx = 0, mrx, b;
  logic [63:0] e;
  logic [63:0] rd_q[$];
  logic [7:0]  link_q[$];
  int          failures = 0, compares = 0, half = 0, hc = 0, n;
  int          sels[3] = '{1, 0, 2};
  int          pres[3] = '{1, 4, 2};
  wire logic   sck_i = sck_oe_n_o ? sck_drv : sck_o;
  wire logic   mosi_i = mosi_oe_n_o ? mosi_drv : mosi_o;
  wire logic   miso_i = miso_oe_n_o ? mmiso : miso_o;
  wire logic   ss_n_i = ss_oe_n_o ? ss_drv : ss_n_o;
  wire logic   mss = ss_oe_n_o | ss_n_o;
  always #5 clk_i = ~clk_i;
  spm_core uut (.*);
  spm_slave_model partner (.clk_i, .ss_n_i(mss), .sck_i, .mosi_i, .tx_i(mtx),
    .miso_o(mmiso), .rx_o(mrx), .done_o(mdone));
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] x);
    int k;
    @(posedge clk_i);
    if (!wr) rd_q.push_back({m, x});
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    if (k >= 50) begin
      failures++;
      wrap_up();
    end
    rdata = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task automatic poll(input int bit_i);
    n = 0;
    do begin
      bus(0, spm_pkg::ADDR_STATUS, 0, 0, 0);
      n++;
    end while (rdata[bit_i] !== 1'b1 && n < 400);
    if (n >= 400) begin
      failures++;
      wrap_up();
    end
  endtask : poll
  task automatic link_frame(input logic [7:0] w);
    ss_drv   <= 1'b0;
    mosi_drv <= w[7];
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge clk_i);
      sck_drv <= 1'b1;
      repeat (4) @(posedge clk_i);
      sck_drv <= 1'b0;
      if (i > 0) mosi_drv <= w[i-1];
    end
    repeat (4) @(posedge clk_i);
    ss_drv <= 1'b1;
  endtask : link_frame
  always @(posedge clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && rd_q.size() > 0) begin
      e = rd_q.pop_front();
      if (e[63:32] != 0) check((avs_readdata_o & e[63:32]) === e[31:0], "read value");
    end
    if (mdone === 1'b1) check(link_q.size() > 0 && mrx === link_q.pop_front(), "link word");
    if (ss_n_o !== 1'b0) hc = 0;
    else if (sck_o !== sck_p) begin
      if (hc > 0 && measure) check(hc == half, "bit rate");
      hc = 1;
    end else if (hc > 0) hc++;
    sck_p = sck_o;
  end
  initial begin
    void'($urandom(34342));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, spm_pkg::ADDR_DATA, 0, 32'h0000_00ff, 0);
    bus(0, spm_pkg::ADDR_CTRL, 0, 32'h0000_01ff, 32'h0000_0004);
    bus(0, 4'h2, 0, 32'hffff_ffff, 0);
    check(irq_o === 1'b0, "irq while disabled");
    $display("test reset done");
    bus(1, spm_pkg::ADDR_CTRL, 32'h0000_009c, 0, 0);
    repeat (2) @(posedge clk_i);
    check(sck_oe_n_o === 1'b0 && irq_o === 1'b1, "master idle pins");
    for (int i = 0; i < 3; i++) begin
      half = (pres[i] + 1) << sels[i];
      bus(1, spm_pkg::ADDR_BAUD, 32'((pres[i] << 4) | sels[i]), 0, 0);
      b = 8'($urandom);
      mtx <= 8'($urandom);
      link_q.push_back(b);
      bus(0, spm_pkg::ADDR_STATUS, 0, 32'h0000_0002, 32'h0000_0002);
      measure <= (i != 1);
      bus(1, spm_pkg::ADDR_DATA, {24'h0, b}, 0, 0);
      if (i == 1) begin
        repeat (20) @(posedge clk_i);
        stop_mode_i <= 1'b1;
        repeat (30) @(posedge clk_i);
        stop_mode_i <= 1'b0;
        ce_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        ce_i <= 1'b1;
      end
      poll(spm_pkg::ST_DONE);
      bus(0, spm_pkg::ADDR_DATA, 0, 32'h0000_00ff, {24'h0, mtx});
    end
    $display("test master transfers done");
    bus(1, spm_pkg::ADDR_CTRL, 32'h0000_00fc, 0, 0);
    repeat (2) @(posedge clk_i);
    check(mosi_oe_n_o === 1'b0, "bidir drive");
    bus(1, spm_pkg::ADDR_CTRL, 32'h0000_00bc, 0, 0);
    repeat (2) @(posedge clk_i);
    check(mosi_oe_n_o === 1'b1, "bidir input");
    $display("test pin roles done");
    bus(1, spm_pkg::ADDR_CTRL, 32'h0000_0094, 0, 0);
    ss_drv <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(irq_o === 1'b1, "fault irq");
    bus(0, spm_pkg::ADDR_STATUS, 0, 32'h0000_0001, 32'h0000_0001);
    bus(0, spm_pkg::ADDR_CTRL, 0, 32'h0000_0004, 0);
    ss_drv <= 1'b1;
    bus(1, spm_pkg::ADDR_CTRL, 32'h0000_0010, 0, 0);
    bus(0, spm_pkg::ADDR_STATUS, 0, 32'h0000_0001, 0);
    repeat (2) @(posedge clk_i);
    check(irq_o === 1'b0, "irq after disable");
    $display("test mode fault done");
    bus(1, spm_pkg::ADDR_CTRL, 32'h0000_0180, 0, 0);
    wait_mode_i <= 1'b1;
    b = 8'($urandom);
    link_frame(b);
    bus(0, spm_pkg::ADDR_STATUS, 0, 32'h0000_0004, 0);
    wait_mode_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(0, spm_pkg::ADDR_STATUS, 0, 32'h0000_0004, 32'h0000_0004);
    bus(0, spm_pkg::ADDR_DATA, 0, 32'h0000_00ff, {24'h0, b});
    wait_mode_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wait_mode_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(0, spm_pkg::ADDR_STATUS, 0, 32'h0000_0004, 0);
    $display("test slave wait done");
    wrap_up();
  end
endmodule : spm_core_tb
bind spm_core spm_monitor mon (.*);

// ===== tb/spm_monitor.sv
// concurrent checks on the serial port block's bus and pins
`timescale 1ns/10ps
module spm_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        stop_mode_i,
  input wire logic        sck_i,
  input wire logic        sck_o,
  input wire logic        sck_oe_n_o,
  input wire logic        mosi_o,
  input wire logic        miso_oe_n_o,
  input wire logic        ss_n_o,
  input wire logic        ss_oe_n_o,
  input wire logic        irq_o
);
  logic sck_q;
  logic rx_seen;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    sck_q   <= sck_i;
    rx_seen <= !rst_i && (rx_seen || sck_i != sck_q);
  end
  chk_req_answer: assert property (
    $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o) else $error("no answer in one cycle");
  chk_ack_pulse: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o) else $error("waitrequest low too long");
  chk_data_zero: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == spm_pkg::ADDR_DATA && !rx_seen
    |-> avs_readdata_o == spm_pkg::READ_ZERO) else $error("data not zero after reset");
  chk_sck_framed: assert property (
    !ss_oe_n_o && !sck_oe_n_o && $changed(sck_o) |-> !ss_n_o) else $error("clock outside select");
  chk_miso_master: assert property (
    !sck_oe_n_o |-> miso_oe_n_o) else $error("master drives its input pin");
  chk_stop_freeze: assert property (
    !sck_oe_n_o && stop_mode_i && $past(stop_mode_i) && $past(stop_mode_i, 2)
    |-> $stable(sck_o) && $stable(mosi_o))
    else $error("master moved in stop");
  chk_ce_freeze: assert property (
    !ce_i ##1 !ce_i |-> $stable({sck_o, mosi_o, ss_n_o, irq_o})) else $error("moved while held");
  chk_irq_reset: assert property (
    $past(rst_i) |-> !irq_o) else $error("interrupt right after reset");
  cov_frame: cover property ($fell(ss_n_o));
  cov_stop: cover property (stop_mode_i && !ss_n_o);
  cov_irq: cover property ($rose(irq_o));
endmodule : spm_monitor

// ===== tb/spm_slave_model.sv
// behavioural far-side serial slave, clock phase and polarity zero
`timescale 1ns/10ps
module spm_slave_model (
  input  wire logic       clk_i,
  input  wire logic       ss_n_i,
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic      [7:0] rx_o,
  output logic            done_o
);
  logic       sck_q;
  logic [7:0] sh;
  int         cnt;
  initial miso_o = 1'b0;
  always @(posedge clk_i) begin
    sck_q  <= sck_i;
    done_o <= 1'b0;
    if (ss_n_i) begin
      // released line toggles so no stale level survives
      miso_o <= ~miso_o;
      sh     <= tx_i;
      cnt    <= 0;
    end else if (sck_i && !sck_q) begin
      // master clock shifts word in msb first
      rx_o   <= {rx_o[6:0], mosi_i};
      cnt    <= cnt + 1;
      done_o <= (cnt == 7);
    end else if (!sck_i && sck_q) begin
      sh     <= {sh[6:0], 1'b0};
      miso_o <= sh[6];
    end else if (cnt == 0) begin
      miso_o <= sh[7];
    end
  end
endmodule : spm_slave_model

// ===== verilog/spm_core.sv
// serial peripheral port with register slave, rate generator and low-power handling
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
module spm_core #(
  parameter int DATA_W = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        wait_mode_i,
  input  wire logic        stop_mode_i,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_n_o,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe_n_o,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe_n_o,
  input  wire logic        ss_n_i,
  output logic             ss_n_o,
  output logic             ss_oe_n_o,
  output logic             irq_o
);
  localparam int CNT_W = $clog2(DATA_W + 1);
  localparam logic [CNT_W-1:0] BITS = CNT_W'(DATA_W);

  // synchronisers for pins
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic       sck_prev;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // idle levels: select high, clock low
      sync_a <= 4'h8;
      sync_b <= 4'h8;
    end else if (ce_i) begin
      sync_a <= {ss_n_i, miso_i, mosi_i, sck_i};
      sync_b <= sync_a;
    end
  end
  wire logic sck_s  = sync_b[0];
  wire logic mosi_s = sync_b[1];
  wire logic miso_s = sync_b[2];
  wire logic ss_s   = sync_b[3];

  // registers
  logic [spm_pkg::CTL_WIDTH-1:0] ctrl;
  logic [6:0]        baud;
  logic [DATA_W-1:0] tx_data;
  logic [DATA_W-1:0] rx_data;
  logic              tx_full;
  logic              done_flag;
  logic              mode_fault_flag_flag;
  logic              status_seen;
  logic              done_seen;
  logic              mode_fault_flag_seen;

  wire logic is_master = ctrl[spm_pkg::CTL_MASTER];
  wire logic enabled   = ctrl[spm_pkg::CTL_ENABLE];
  wire logic clock_polarity_bit      = ctrl[spm_pkg::CTL_POL];
  wire logic clock_phase_bit      = ctrl[spm_pkg::CTL_PHASE];
  wire logic bidir     = ctrl[spm_pkg::CTL_PINCTL];
  // stop always counts as low power and halts the master, wait counts only when selected
  wire logic low_power = stop_mode_i | (wait_mode_i & ctrl[spm_pkg::CTL_WAITSEL]);
  wire logic run       = ce_i & ~stop_mode_i;

  // shift engine
  logic [DATA_W-1:0] shifter;
  logic [CNT_W-1:0]  bit_cnt;
  logic              busy;
  logic              half;
  logic              lp_q;
  logic [11:0]       div_cnt;
  logic              rx_pending;
  logic              slave_done;
  logic              s_in;

  // divisor = (pre+1) * 2^(sel+1) system clocks per bit
  function automatic logic [11:0] half_period(input logic [6:0] b);
    logic [11:0] pre;
    pre = 12'(b[6:4]) + 12'h001;
    return 12'(pre << b[2:0]) - 12'h001;
  endfunction : half_period

  // address match for a register access
  function automatic logic addr_is(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction : addr_is

  wire logic at_ctrl   = addr_is(avs_address_i, spm_pkg::ADDR_CTRL);
  wire logic at_baud   = addr_is(avs_address_i, spm_pkg::ADDR_BAUD);
  wire logic at_status = addr_is(avs_address_i, spm_pkg::ADDR_STATUS);
  wire logic at_data   = addr_is(avs_address_i, spm_pkg::ADDR_DATA);

  // fault when select pin pulled low while a fault-enabled master
  wire logic fault = enabled & is_master & ctrl[spm_pkg::CTL_MODE_FAULT_ENABLE] &
                     ~ctrl[spm_pkg::CTL_SELECT_OUTPUT_ENABLE] & ~ss_s;
  wire logic wr_hit = avs_write_i & ~avs_waitrequest_o;
  wire logic rd_hit = avs_read_i & ~avs_waitrequest_o;
  wire logic wr_data = wr_hit & at_data;
  // data write takes only after status read with empty flag
  wire logic load = wr_data & status_seen & ~tx_full;
  wire logic m_fin = busy & is_master & half & (div_cnt == 12'h000) & (bit_cnt == BITS);
  // master input pin, or shared output pin in single-wire mode
  wire logic m_in  = bidir ? mosi_s : miso_s;
  wire logic sl_in = bidir ? miso_s : mosi_s;

  // slave clock edges
  wire logic sck_rise = sck_s & ~sck_prev;
  wire logic sck_fall = ~sck_s & sck_prev;
  wire logic lead     = clock_polarity_bit ? sck_fall : sck_rise;
  wire logic trail    = clock_polarity_bit ? sck_rise : sck_fall;
  // phase selects sampling on leading or trailing edges
  wire logic s_samp   = clock_phase_bit ? trail : lead;
  wire logic s_shift  = clock_phase_bit ? lead : trail;

  // master rate generator and shifter, slave shifter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy     <= 1'b0;
      half     <= 1'b0;
      lp_q     <= 1'b0;
      div_cnt  <= 12'h000;
      bit_cnt  <= '0;
      shifter  <= '0;
      sck_prev <= 1'b0;
      s_in     <= 1'b0;
      rx_pending <= 1'b0;
    end else if (ce_i) begin
      sck_prev <= sck_s;
      lp_q     <= low_power;
      if (fault | mode_fault_flag_flag | ~enabled) begin
        busy    <= 1'b0;
        half    <= 1'b0;
        bit_cnt <= '0;
        rx_pending <= 1'b0;
      end else if (is_master) begin
        if (run) begin
          if (!busy && tx_full) begin
            // word moves into the shifter and transfer starts
            busy    <= 1'b1;
            shifter <= tx_data;
            div_cnt <= half_period(baud);
            half    <= 1'b0;
            bit_cnt <= '0;
          end else if (busy) begin
            if (div_cnt != 12'h000) begin
              div_cnt <= div_cnt - 12'h001;
            end else begin
              div_cnt <= half_period(baud);
              half    <= ~half;
              // master toggles its clock per half period
              if (!half) begin
                bit_cnt <= bit_cnt + CNT_W'(1);
              end else begin
                // circular exchange, one bit per clock
                // input taken at bit end to cover pin round trip
                shifter <= {shifter[DATA_W-2:0], m_in};
                if (bit_cnt == BITS) begin
                  busy <= 1'b0;
                end
              end
            end
          end
        end
      end else begin
        // slave follows external clock even in stop
        // slave shifts whatever the shifter holds
        if (!ss_s) begin
          if (!busy && !clock_phase_bit && tx_full) begin
            shifter <= tx_data;
          end
          if (s_samp) begin
            s_in    <= sl_in;
            busy    <= 1'b1;
          end
          if (s_shift && busy) begin
            shifter <= {shifter[DATA_W-2:0], s_in};
            bit_cnt <= bit_cnt + CNT_W'(1);
          end
        end else begin
          busy    <= 1'b0;
          bit_cnt <= '0;
        end
        if (bit_cnt == BITS) begin
          bit_cnt    <= '0;
          busy       <= 1'b0;
          rx_pending <= 1'b1;
        // pending word lost on low power entry
        end else if (rx_pending && low_power && !lp_q) begin
          rx_pending <= 1'b0;
        end else if (rx_pending && !low_power) begin
          rx_pending <= 1'b0;
        end
      end
    end
  end
  // slave completion waits for low power exit
  // idle wait periods generate no completion
  assign slave_done = ~is_master & rx_pending & ~low_power;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_o       <= 1'b0;
      sck_oe_n_o  <= 1'b1;
      ss_n_o      <= 1'b1;
      ss_oe_n_o   <= 1'b1;
      mosi_o      <= 1'b0;
      mosi_oe_n_o <= 1'b1;
      miso_o      <= 1'b0;
      miso_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      sck_o       <= clock_polarity_bit ^ (busy & is_master & (half ^ clock_phase_bit));
      sck_oe_n_o  <= ~(enabled & is_master);
      // select held low until the clock is back at idle
      ss_n_o      <= ~((busy | (sck_o ^ clock_polarity_bit)) & is_master);
      ss_oe_n_o   <= ~(enabled & is_master & ctrl[spm_pkg::CTL_MODE_FAULT_ENABLE] &
                       ctrl[spm_pkg::CTL_SELECT_OUTPUT_ENABLE]);
      // data pin direction from role and pin control
      mosi_o      <= shifter[DATA_W-1];
      miso_o      <= shifter[DATA_W-1];
      mosi_oe_n_o <= ~(enabled & is_master & (~bidir | ctrl[spm_pkg::CTL_BIDIRECTIONAL_OUTPUT_ENABLE]));
      miso_oe_n_o <= ~(enabled & ~is_master & ~ss_s &
                       (~bidir | ctrl[spm_pkg::CTL_BIDIRECTIONAL_OUTPUT_ENABLE]));
    end
  end

  // control and baud registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= spm_pkg::CTL_RESET;
      baud <= spm_pkg::BAUD_RESET;
    end else if (ce_i) begin
      if (wr_hit && at_ctrl) begin
        if (avs_byteenable_i[0]) begin
          ctrl[7:0] <= avs_writedata_i[7:0];
        end
        if (avs_byteenable_i[1]) begin
          ctrl[spm_pkg::CTL_WAITSEL] <= avs_writedata_i[spm_pkg::CTL_WAITSEL];
        end
      end
      if (wr_hit && at_baud && avs_byteenable_i[0]) begin
        baud <= avs_writedata_i[6:0];
      end
      // fault returns the port to slave role
      // master bit cleared by mode fault
      if (fault) begin
        ctrl[spm_pkg::CTL_MASTER] <= 1'b0;
      end
    end
  end

  // transmit, receive and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data     <= '0;
      tx_full     <= 1'b0;
      // receive register reads zero after reset
      rx_data     <= '0;
      done_flag   <= 1'b0;
      mode_fault_flag_flag   <= 1'b0;
      status_seen <= 1'b0;
      done_seen   <= 1'b0;
      mode_fault_flag_seen   <= 1'b0;
    end else if (ce_i) begin
      if (rd_hit && at_status) begin
        status_seen <= ~tx_full;
        done_seen   <= done_flag;
        mode_fault_flag_seen   <= mode_fault_flag_flag;
      end
      if (load) begin
        tx_data     <= avs_writedata_i[DATA_W-1:0];
        tx_full     <= 1'b1;
        status_seen <= 1'b0;
      end
      // empty once master shifter has taken the word, or at once for a disabled master, or once slave is busy
      if (tx_full && !busy && is_master && run && !fault && !mode_fault_flag_flag) begin
        tx_full <= 1'b0;
      end else if (tx_full && !is_master && busy) begin
        tx_full <= 1'b0;
      end
      // completion: set wins over clear
      if (m_fin || slave_done) begin
        done_flag <= 1'b1;
        rx_data   <= m_fin ? {shifter[DATA_W-2:0], m_in} : shifter;
      end else if (rd_hit && avs_address_i == spm_pkg::ADDR_DATA && done_seen) begin
        done_flag <= 1'b0;
        done_seen <= 1'b0;
      end
      // mode fault flag set by select fault
      if (fault) begin
        mode_fault_flag_flag <= 1'b1;
      end else if (wr_hit && avs_address_i == spm_pkg::ADDR_CTRL && mode_fault_flag_seen) begin
        mode_fault_flag_flag <= 1'b0;
        mode_fault_flag_seen <= 1'b0;
      end
    end
  end

  // bus answer: one wait cycle per access
  // waitrequest drops for one cycle, then rises again
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= spm_pkg::READ_ZERO;
    end else if (ce_i) begin
      unique case (avs_address_i)
        spm_pkg::ADDR_CTRL:   avs_readdata_o <= 32'(ctrl);
        spm_pkg::ADDR_BAUD:   avs_readdata_o <= 32'(baud);
        spm_pkg::ADDR_STATUS: avs_readdata_o <= 32'({busy, done_flag, ~tx_full, mode_fault_flag_flag});
        spm_pkg::ADDR_DATA:   avs_readdata_o <= 32'(rx_data);
        default:              avs_readdata_o <= spm_pkg::READ_ZERO;
      endcase
    end
  end

  // interrupt stands while fault, done or transmit-empty flag set and port enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= enabled & (mode_fault_flag_flag | done_flag | ~tx_full);
    end
  end
endmodule : spm_core

// ===== verilog/spm_pkg.sv
// constants for the serial port block
package spm_pkg;
  // register byte offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_BAUD   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_DATA   = 4'hC;
  // control register bit positions
  localparam int CTL_PHASE   = 0;
  localparam int CTL_POL     = 1;
  localparam int CTL_MASTER  = 2;
  localparam int CTL_SELECT_OUTPUT_ENABLE    = 3;
  localparam int CTL_MODE_FAULT_ENABLE  = 4;
  localparam int CTL_PINCTL  = 5;
  localparam int CTL_BIDIRECTIONAL_OUTPUT_ENABLE = 6;
  localparam int CTL_ENABLE  = 7;
  localparam int CTL_WAITSEL = 8;
  localparam int CTL_WIDTH   = 9;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 9'h004;
  // baud register fields
  localparam int BAUD_SEL_LSB = 0;
  localparam int BAUD_PRE_LSB = 4;
  localparam logic [6:0] BAUD_RESET = 7'h00;
  // status register bit positions
  localparam int ST_MODE_FAULT_FLAG  = 0;
  localparam int ST_TXE   = 1;
  localparam int ST_DONE  = 2;
  localparam int ST_BUSY  = 3;
  // unmapped read value
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : spm_pkg
